// ==== core/aos_defines.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the oversampling and dual sync block.
// Assumes: 32-bit APB register words at aligned byte addresses.
// Notes:   Definitions only.
`ifndef AOS_DEFINES_SVH
`define AOS_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AOS_OVS_CTRL_OFS   12'h000
`define AOS_SYNC_CTRL_OFS  12'h004
`define AOS_STATUS_OFS     12'h008
`define AOS_PRI_RESULT_OFS 12'h00C
`define AOS_SEC_RESULT_OFS 12'h010
`define AOS_PACKED_OFS     12'h014

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AOS_OVS_EN_BIT      0
`define AOS_OVS_RATIO_LSB   2
`define AOS_OVS_SHIFT_LSB   5
`define AOS_SYNC_MODE_LSB   0
`define AOS_TRIG_SRC_BIT    4
`define AOS_SW_TRIG_BIT     5
`define AOS_DMA_EN_BIT      6
`define AOS_PRI_EOCIE_BIT   7
`define AOS_SEC_EOCIE_BIT   8

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define AOS_OVS_CTRL_RST    32'h0000_0000
`define AOS_SYNC_CTRL_RST   32'h0000_0000
`define AOS_FAST_DELAY      7
`define AOS_SLOW_DELAY      14
`define AOS_MAX_SHIFT       8

`endif

// ==== core/aos_pkg.sv ====
// Purpose: Types shared by the oversampling and dual sync block.
// Assumes: Nothing beyond the defines header.
// Notes:   Holds types only; numbers live in the defines header.
`default_nettype none
package aos_pkg;

   typedef enum logic [3:0] {
      AOS_MODE_FREE     = 4'h0,
      AOS_MODE_PARALLEL = 4'h6,
      AOS_MODE_FAST     = 4'h7,
      AOS_MODE_SLOW     = 4'h8
   } aos_sync_mode_t;

   typedef struct packed {
      logic        valid;
      logic [11:0] data;
   } aos_conv_t;

   typedef struct packed {
      logic        enable;
      logic [2:0]  ratioSel;
      logic [3:0]  shiftSel;
   } aos_ovs_cfg_t;

endpackage
`default_nettype wire

// ==== core/aos_oversampler.sv ====
// Purpose: Accumulates N conversions, shifts, rounds and keeps 16 bits.
// Assumes: One conversion result per valid pulse.
// Notes:   Bypass passes the raw result when disabled.
`default_nettype none
module aos_oversampler #(
   parameter int ACC_W = 20
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire aos_pkg::aos_ovs_cfg_t cfg,
   input  wire aos_pkg::aos_conv_t    conv,
   output logic                       resValid,
   output logic [15:0]                resData
);

   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] acc_d;
   logic [8:0]       cnt_q;
   logic [8:0]       ratio;
   logic             lastConv;
   logic [ACC_W:0]   rounded;
   logic [ACC_W:0]   shifted;

   // ----------------------------------------
   // Ratio, rounding and truncation
   // ----------------------------------------
   assign ratio    = 9'h002 << cfg.ratioSel;
   assign acc_d    = acc_q + {{(ACC_W-12){1'b0}}, conv.data};
   assign lastConv = (cnt_q == ratio - 9'h001);
   // Half of the shift weight is added so the shift rounds to nearest.
   assign rounded  = (cfg.shiftSel == 4'h0) ? {1'b0, acc_d} :
                     {1'b0, acc_d} + ((ACC_W+1)'(1) << (cfg.shiftSel - 4'h1));
   assign shifted  = rounded >> ((cfg.shiftSel > 4'h8) ? 4'h8 : cfg.shiftSel);

   always_ff @(posedge clk) begin
      if (rst || !cfg.enable) begin
         acc_q <= '0;
         cnt_q <= '0;
      end else if (conv.valid) begin
         acc_q <= lastConv ? '0 : acc_d;
         cnt_q <= lastConv ? 9'h000 : cnt_q + 9'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         resValid <= 1'b0;
         resData  <= 16'h0000;
      end else begin
         resValid <= conv.valid && (!cfg.enable || lastConv);
         if (conv.valid && !cfg.enable) begin
            resData <= {4'h0, conv.data};
         end else if (conv.valid && lastConv) begin
            resData <= shifted[15:0];
         end
      end
   end

endmodule
`default_nettype wire

// ==== core/aos_trigger_delay.sv ====
// Purpose: Delays the primary start pulse by a programmable count for the secondary.
// Assumes: Triggers come only when both converters are idle.
// Notes:   A new trigger during the wait restarts the count.
`default_nettype none
module aos_trigger_delay (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic [3:0] delay,
   output logic            fire
);

   logic [3:0] cnt_q;
   logic       busy_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q  <= 4'h0;
         busy_q <= 1'b0;
         fire   <= 1'b0;
      end else begin
         fire <= 1'b0;
         if (start) begin
            cnt_q  <= delay - 4'h1;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (cnt_q == 4'h1) begin
               fire   <= 1'b1;
               busy_q <= 1'b0;
            end
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end

endmodule
`default_nettype wire

// ==== core/aos_dual_sync.sv ====
// Purpose: Oversampling post-processing and dual converter sync control with an APB register file.
// Assumes: Converter cores give one-cycle result pulses on clk; the external trigger is a pin.
// Notes:   Conversion timing itself belongs to the cores and is not changed here.
`default_nettype none
`include "aos_defines.svh"

// Summary of operation
// - With oversampling on, sum N results and right shift to a word up to 16 bits.
// - Ratio field of three bits selects N from 2 to 256 in powers of two.
// - Shift field of four bits selects a shift of 0 to 8 bits.
// - Accumulator holds at least 20 bits so 256 full-scale results never overflow.
// - Round the shifted sum to nearest, keep the low 16 bits.
// - Upper bits beyond 16 are dropped, never saturated.
// - Sampling and conversion timing per conversion stays as in normal operation.
// - One averaged result per N completed conversions.
// - Free mode: converters run independently, no trigger or data sharing.
// - Parallel mode: both start together on the primary's selected trigger.
// - Mode 0111 is follow-up fast, mode 1000 is follow-up slow.
// - Synchronised modes pack secondary data high and primary data low for DMA.
// - Synchronised modes make secondary data readable through the primary result register.
// - Parallel mode: each converter with end-of-conversion enabled raises its event.
// - Fast follow-up: secondary starts seven clocks after the primary.
// - Slow follow-up: secondary starts fourteen clocks after the primary.
module aos_dual_sync (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        extTrigPin,
   input  wire logic        priSwTrig,
   input  wire logic        secSwTrig,
   input  wire logic        priConvDone,
   input  wire logic [11:0] priConvData,
   input  wire logic        secConvDone,
   input  wire logic [11:0] secConvData,
   output logic             priStart,
   output logic             secStart,
   output logic             priEoc,
   output logic             secEoc,
   output logic             dmaReq,
   output logic      [31:0] dmaData
);

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   aos_pkg::aos_ovs_cfg_t   ovsCfg_q;
   aos_pkg::aos_sync_mode_t mode_q;
   logic                    trigSrcSel_q;
   logic                    dmaEn_q;
   logic                    priEocie_q;
   logic                    secEocie_q;
   logic             [15:0] priResult_q;
   logic             [15:0] secResult_q;
   logic                    priNew_q;
   logic                    secNew_q;
   logic              [2:0] trigSync_q;
   logic                    swTrigReq_q;
   logic                    extEdge;
   logic                    priTrig;
   logic                    synced;
   logic              [3:0] followDelay;
   logic                    followStart;
   logic                    delayedFire;
   logic                    priOvsValid;
   logic             [15:0] priOvsData;
   logic                    secOvsValid;
   logic             [15:0] secOvsData;
   logic                    pairReady;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic        acc;
   logic        wrOvs;
   logic        wrSync;
   logic        mapped;
   logic [31:0] rdMux;
   logic [31:0] packedWord;

   assign acc    = psel && penable;
   assign mapped = (paddr == `AOS_OVS_CTRL_OFS) || (paddr == `AOS_SYNC_CTRL_OFS) ||
                   (paddr == `AOS_STATUS_OFS) || (paddr == `AOS_PRI_RESULT_OFS) ||
                   (paddr == `AOS_SEC_RESULT_OFS) || (paddr == `AOS_PACKED_OFS);
   assign wrOvs  = acc && pwrite && (paddr == `AOS_OVS_CTRL_OFS);
   assign wrSync = acc && pwrite && (paddr == `AOS_SYNC_CTRL_OFS);
   assign synced = (mode_q != aos_pkg::AOS_MODE_FREE);
   assign packedWord = {secResult_q, priResult_q};

   // In synced modes the primary result register shows the packed pair.
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (paddr)
         `AOS_OVS_CTRL_OFS:   rdMux = {23'h0, ovsCfg_q.shiftSel, ovsCfg_q.ratioSel, 1'b0, ovsCfg_q.enable};
         `AOS_SYNC_CTRL_OFS:  rdMux = {23'h0, secEocie_q, priEocie_q, dmaEn_q, 1'b0, trigSrcSel_q, mode_q};
         `AOS_STATUS_OFS:     rdMux = {30'h0, secNew_q, priNew_q};
         `AOS_PRI_RESULT_OFS: rdMux = synced ? packedWord : {16'h0, priResult_q};
         `AOS_SEC_RESULT_OFS: rdMux = {16'h0, secResult_q};
         `AOS_PACKED_OFS:     rdMux = packedWord;
         default:             rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !pready && !penable ? 1'b0 : (acc && !pready);
         pslverr <= acc && !pready && !mapped;
         if (acc && !pready && !pwrite) begin
            prdata <= rdMux;
         end
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic wrTake;
   assign wrTake = acc && pready;

   always_ff @(posedge clk) begin
      if (rst) begin
         ovsCfg_q     <= '0;
         mode_q       <= aos_pkg::AOS_MODE_FREE;
         trigSrcSel_q <= 1'b0;
         dmaEn_q      <= 1'b0;
         priEocie_q   <= 1'b0;
         secEocie_q   <= 1'b0;
      end else begin
         if (wrOvs && wrTake) begin
            ovsCfg_q.enable   <= pwdata[`AOS_OVS_EN_BIT];
            ovsCfg_q.ratioSel <= pwdata[`AOS_OVS_RATIO_LSB +: 3];
            ovsCfg_q.shiftSel <= (pwdata[`AOS_OVS_SHIFT_LSB +: 4] > 4'h8) ? 4'h8 :
                                 pwdata[`AOS_OVS_SHIFT_LSB +: 4];
         end
         if (wrSync && wrTake) begin
            // Codes outside the table fall back to free mode.
            unique case (pwdata[`AOS_SYNC_MODE_LSB +: 4])
               4'h6:    mode_q <= aos_pkg::AOS_MODE_PARALLEL;
               4'h7:    mode_q <= aos_pkg::AOS_MODE_FAST;
               4'h8:    mode_q <= aos_pkg::AOS_MODE_SLOW;
               default: mode_q <= aos_pkg::AOS_MODE_FREE;
            endcase
            trigSrcSel_q <= pwdata[`AOS_TRIG_SRC_BIT];
            dmaEn_q      <= pwdata[`AOS_DMA_EN_BIT];
            priEocie_q   <= pwdata[`AOS_PRI_EOCIE_BIT];
            secEocie_q   <= pwdata[`AOS_SEC_EOCIE_BIT];
         end
      end
   end

   // ----------------------------------------
   // Trigger path
   // ----------------------------------------
   // The pin passes three flops; a rising edge counts once stages two and three agree.
   always_ff @(posedge clk) begin
      if (rst) begin
         trigSync_q  <= 3'h0;
         swTrigReq_q <= 1'b0;
      end else begin
         trigSync_q  <= {trigSync_q[1:0], extTrigPin};
         swTrigReq_q <= wrSync && wrTake && pwdata[`AOS_SW_TRIG_BIT];
      end
   end

   logic trigLevel_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         trigLevel_q <= 1'b0;
      end else if (trigSync_q[2] == trigSync_q[1]) begin
         trigLevel_q <= trigSync_q[2];
      end
   end

   assign extEdge     = (trigSync_q[2] == trigSync_q[1]) && trigSync_q[2] && !trigLevel_q;
   assign priTrig     = trigSrcSel_q ? (swTrigReq_q || priSwTrig) : extEdge;
   assign followDelay = (mode_q == aos_pkg::AOS_MODE_SLOW) ? 4'(`AOS_SLOW_DELAY) : 4'(`AOS_FAST_DELAY);
   assign followStart = priTrig && ((mode_q == aos_pkg::AOS_MODE_FAST) || (mode_q == aos_pkg::AOS_MODE_SLOW));

   aos_trigger_delay u_delay (
      .clk   (clk),
      .rst   (rst),
      .start (followStart),
      .delay (followDelay),
      .fire  (delayedFire)
   );

   // The core's own sampling time is untouched; only start pulses are steered.
   always_ff @(posedge clk) begin
      if (rst) begin
         priStart <= 1'b0;
         secStart <= 1'b0;
      end else begin
         priStart <= priTrig;
         unique case (mode_q)
            aos_pkg::AOS_MODE_FREE:     secStart <= secSwTrig;
            aos_pkg::AOS_MODE_PARALLEL: secStart <= priTrig;
            aos_pkg::AOS_MODE_FAST:     secStart <= delayedFire;
            aos_pkg::AOS_MODE_SLOW:     secStart <= delayedFire;
         endcase
      end
   end

   // ----------------------------------------
   // Result path
   // ----------------------------------------
   aos_oversampler u_priOvs (
      .clk      (clk),
      .rst      (rst),
      .cfg      (ovsCfg_q),
      .conv     ({priConvDone, priConvData}),
      .resValid (priOvsValid),
      .resData  (priOvsData)
   );

   aos_oversampler u_secOvs (
      .clk      (clk),
      .rst      (rst),
      .cfg      (ovsCfg_q),
      .conv     ({secConvDone, secConvData}),
      .resValid (secOvsValid),
      .resData  (secOvsData)
   );

   // In synced modes a DMA word goes out once both halves of a pair have arrived.
   assign pairReady = (priNew_q || priOvsValid) && (secNew_q || secOvsValid);

   always_ff @(posedge clk) begin
      if (rst) begin
         priResult_q <= 16'h0000;
         secResult_q <= 16'h0000;
         priNew_q    <= 1'b0;
         secNew_q    <= 1'b0;
         priEoc      <= 1'b0;
         secEoc      <= 1'b0;
         dmaReq      <= 1'b0;
         dmaData     <= 32'h0000_0000;
      end else begin
         if (priOvsValid) begin
            priResult_q <= priOvsData;
         end
         if (secOvsValid) begin
            secResult_q <= secOvsData;
         end
         priEoc <= priOvsValid && priEocie_q;
         secEoc <= secOvsValid && secEocie_q;
         if (synced && pairReady) begin
            dmaReq   <= dmaEn_q;
            dmaData  <= {secOvsValid ? secOvsData : secResult_q,
                         priOvsValid ? priOvsData : priResult_q};
            priNew_q <= 1'b0;
            secNew_q <= 1'b0;
         end else begin
            dmaReq   <= !synced && dmaEn_q && priOvsValid;
            dmaData  <= priOvsValid ? {16'h0, priOvsData} : dmaData;
            priNew_q <= synced && (priNew_q || priOvsValid);
            secNew_q <= synced && (secNew_q || secOvsValid);
         end
      end
   end

endmodule
`default_nettype wire

// ==== verification/aos_dual_sync_props.sv ====
// Purpose: Port-level timing and packing checks for the oversampling and dual sync block.
// Assumes: Legal mode codes only; ratio changes only with oversampling off.
// Notes:   Written control fields are mirrored in helper registers.
`default_nettype none
`include "aos_defines.svh"
module aos_dual_sync_props (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        secSwTrig,
   input wire logic        priConvDone,
   input wire logic [11:0] priConvData,
   input wire logic        secConvDone,
   input wire logic [11:0] secConvData,
   input wire logic        priStart,
   input wire logic        secStart,
   input wire logic        priEoc,
   input wire logic        secEoc,
   input wire logic        dmaReq,
   input wire logic [31:0] dmaData
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [3:0]  modeQ;
   logic [1:0]  eocEnQ;
   logic        ovsEnQ;
   logic [2:0]  ratioQ;
   logic [8:0]  cntQ;
   logic [11:0] priDQ;
   logic [11:0] secDQ;
   wire         wAcc    = psel & penable & pready & pwrite;
   wire         wOvs    = wAcc && paddr == `AOS_OVS_CTRL_OFS;
   wire         wSync   = wAcc && paddr == `AOS_SYNC_CTRL_OFS;
   wire  [8:0]  lastCnt = (9'h002 << ratioQ) - 9'h001;
   wire         nthConv = ovsEnQ && priConvDone && cntQ == lastCnt;
   always_ff @(posedge clk) begin
      if (rst) begin
         modeQ <= 4'h0;
         eocEnQ <= 2'h0;
         ovsEnQ <= 1'b0;
         ratioQ <= 3'h0;
         cntQ <= 9'h000;
      end else begin
         if (wSync) begin
            modeQ <= pwdata[3:0];
            eocEnQ <= pwdata[8:7];
         end
         if (wOvs) begin
            ovsEnQ <= pwdata[0];
            ratioQ <= pwdata[4:2];
         end
         if (wOvs) cntQ <= 9'h000;
         else if (ovsEnQ && priConvDone) cntQ <= nthConv ? 9'h000 : cntQ + 9'h001;
      end
   end
   always_ff @(posedge clk) begin
      if (priConvDone) priDQ <= priConvData;
      if (secConvDone) secDQ <= secConvData;
   end
   a_par_start: assert property (modeQ == 4'h6 && priStart |-> secStart)
      else $error("secondary did not start with primary");
   a_fast_gap: assert property (modeQ == 4'h7 && priStart |-> !secStart [*7] ##1 secStart)
      else $error("fast follow-up gap wrong");
   a_slow_gap: assert property (modeQ == 4'h8 && priStart |-> !secStart [*8] ##1 !secStart [*6] ##1 secStart)
      else $error("slow follow-up gap wrong");
   a_free_alone: assert property ($past(modeQ) == 4'h0 && !$past(secSwTrig) |-> !secStart)
      else $error("secondary started without its own trigger in free mode");
   a_eoc_pri: assert property (modeQ == 4'h6 && !ovsEnQ && eocEnQ[0] && priConvDone |-> ##2 priEoc)
      else $error("primary end event missing");
   a_eoc_sec: assert property (modeQ == 4'h6 && !ovsEnQ && eocEnQ[1] && secConvDone |-> ##2 secEoc)
      else $error("secondary end event missing");
   a_ovs_nth: assert property (eocEnQ[0] && nthConv |-> ##2 priEoc)
      else $error("no result after N conversions");
   a_ovs_gap: assert property (ovsEnQ && priConvDone && !nthConv |-> ##2 !priEoc)
      else $error("result before N conversions");
   a_dma_pack: assert property (dmaReq && modeQ != 4'h0 && !ovsEnQ |-> dmaData == {4'h0, secDQ, 4'h0, priDQ})
      else $error("packed word wrong");
   c_fast: cover property (modeQ == 4'h7 && secStart);
   c_ovs: cover property (ovsEnQ && priEoc);
   c_slow_dma: cover property (modeQ == 4'h8 && dmaReq);
endmodule
`default_nettype wire

// ==== verification/aos_conv_model.sv ====
// Purpose: Two converter cores answering start pulses with one-cycle results.
// Assumes: A start arrives only while its core is idle.
// Notes:   Outside the done pulse the data lines show the inverted value.
`default_nettype none
module aos_conv_model #(
   parameter int CONV_CYC = 15
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        priStart,
   input  wire logic        secStart,
   input  wire logic [11:0] priVal,
   input  wire logic [11:0] secVal,
   output logic             priConvDone,
   output logic             secConvDone,
   output logic      [11:0] priConvData,
   output logic      [11:0] secConvData,
   output logic             busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] priCntQ;
   logic [4:0] secCntQ;
   // Every conversion takes the same count, so oversampling cannot hide a timing change.
   always_ff @(posedge clk) begin
      if (rst) begin
         priCntQ <= 5'h00;
         secCntQ <= 5'h00;
      end else begin
         priCntQ <= priStart ? 5'(CONV_CYC) : priCntQ - {4'h0, priCntQ != 5'h00};
         secCntQ <= secStart ? 5'(CONV_CYC) : secCntQ - {4'h0, secCntQ != 5'h00};
      end
   end
   assign priConvDone = priCntQ == 5'h01;
   assign secConvDone = secCntQ == 5'h01;
   assign priConvData = priConvDone ? priVal : ~priVal;
   assign secConvData = secConvDone ? secVal : ~secVal;
   assign busy = priCntQ != 5'h00 || secCntQ != 5'h00;
endmodule
`default_nettype wire

// ==== verification/tb_aos_dual_sync.sv ====
// Purpose: Self-checking bench for oversampling and dual sync control.
// Assumes: APB answers with one wait state; cores modelled separately.
// Notes:   The primary and secondary trigger inputs are each pulsed once in free mode; other triggers use the register or the pin.
`default_nettype none
`include "aos_defines.svh"
module tb_aos_dual_sync;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst, psel, penable, pwrite, extTrigPin, secSwTrig, priSwTrig, err;
   logic [11:0] paddr, priVal, secVal, priConvData, secConvData;
   logic [31:0] pwdata, prdata, dmaData, rd;
   logic        pready, pslverr, priStart, secStart, priEoc, secEoc, dmaReq, busy;
   logic        priConvDone, secConvDone;
   int          fails, checks;
   logic [2:0]  ratioTab [5] = '{3'h0, 3'h0, 3'h2, 3'h4, 3'h7};
   logic [3:0]  shiftTab [5] = '{4'h0, 4'h2, 4'h5, 4'h0, 4'h8};
   logic [11:0] valTab   [5] = '{12'hFFF, 12'h003, 12'h00F, 12'hFFF, 12'hFFF};
   logic [15:0] expTab   [5] = '{16'h1FFE, 16'h0002, 16'h0004, 16'hFFE0, 16'h0FFF};
   logic [3:0]  modeTab  [3] = '{4'h6, 4'h7, 4'h8};
   aos_dual_sync dut (.*);
   aos_conv_model u_cores (.*);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic guard(input logic bad);
      if (bad) begin
         fails++;
         $display("CHECK FAILED %0t wait expired", $time);
         end_sim();
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      guard(pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Waits until the cores have started and gone idle again, so no trigger lands on a busy core.
   task automatic conv_wait();
      int n;
      for (n = 0; n < 30 && busy !== 1'b1; n++) @(posedge clk);
      guard(busy !== 1'b1);
      for (n = 0; n < 60 && busy !== 1'b0; n++) @(posedge clk);
      guard(busy !== 1'b0);
      repeat (3) @(posedge clk);
   endtask
   task automatic trig(input logic [3:0] m);
      apb(1'b1, `AOS_SYNC_CTRL_OFS, 32'h0000_01F0 | {28'h0, m});
      conv_wait();
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst, psel, penable, pwrite, extTrigPin, secSwTrig, priSwTrig} = 7'h40;
      {paddr, priVal, secVal, pwdata, fails, checks} = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, `AOS_OVS_CTRL_OFS, 32'h0);
      chk(rd, `AOS_OVS_CTRL_RST);
      apb(1'b0, `AOS_SYNC_CTRL_OFS, 32'h0);
      chk(rd, `AOS_SYNC_CTRL_RST);
      apb(1'b0, 12'h020, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, `AOS_OVS_CTRL_OFS, 32'h0000_01E0);
      apb(1'b0, `AOS_OVS_CTRL_OFS, 32'h0);
      chk(rd, 32'h0000_0100);
      apb(1'b1, `AOS_SYNC_CTRL_OFS, 32'h0000_0003);
      apb(1'b0, `AOS_SYNC_CTRL_OFS, 32'h0);
      chk(rd, `AOS_SYNC_CTRL_RST);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, `AOS_OVS_CTRL_OFS, 32'h0);
         apb(1'b1, `AOS_OVS_CTRL_OFS, {23'h0, shiftTab[i], ratioTab[i], 2'b01});
         priVal <= valTab[i];
         repeat (4 << ratioTab[i]) trig(4'h0);
         apb(1'b0, `AOS_PRI_RESULT_OFS, 32'h0);
         chk(rd, {16'h0, expTab[i]});
      end
      apb(1'b1, `AOS_OVS_CTRL_OFS, 32'h0);
      $display("test oversampling done");
      secVal <= 12'hABC;
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, `AOS_SYNC_CTRL_OFS, 32'h0000_01D0);
         priVal <= 12'h5A0 | {8'h0, modeTab[i]};
         trig(modeTab[i]);
         apb(1'b0, `AOS_PACKED_OFS, 32'h0);
         chk(rd, {16'h0ABC, 4'h0, priVal});
         apb(1'b0, `AOS_PRI_RESULT_OFS, 32'h0);
         chk(rd, {16'h0ABC, 4'h0, priVal});
      end
      $display("test sync modes done");
      apb(1'b1, `AOS_SYNC_CTRL_OFS, 32'h0000_01D0);
      apb(1'b1, `AOS_SYNC_CTRL_OFS, 32'h0000_01C6);
      secVal <= 12'h321;
      extTrigPin <= 1'b1;
      conv_wait();
      extTrigPin <= 1'b0;
      apb(1'b0, `AOS_PACKED_OFS, 32'h0);
      chk(rd, {16'h0321, 4'h0, priVal});
      $display("test pin trigger done");
      apb(1'b1, `AOS_SYNC_CTRL_OFS, 32'h0000_01D0);
      {priVal, secVal} <= {12'h123, 12'h456};
      priSwTrig <= 1'b1;
      @(posedge clk);
      priSwTrig <= 1'b0;
      conv_wait();
      secSwTrig <= 1'b1;
      @(posedge clk);
      secSwTrig <= 1'b0;
      conv_wait();
      apb(1'b0, `AOS_SEC_RESULT_OFS, 32'h0);
      chk(rd, 32'h0000_0456);
      apb(1'b0, `AOS_PRI_RESULT_OFS, 32'h0);
      chk(rd, 32'h0000_0123);
      $display("test free mode done");
      end_sim();
   end
endmodule
bind aos_dual_sync aos_dual_sync_props u_props (.*);
`default_nettype wire
